/* File: bench/arp_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module arp_host_model
(
   input wire logic i_clk,
   input wire logic i_sdo,
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_rd_n,
   output logic o_chain
);
   // ----------------------------------------
   // Host side of the serial and parallel pins
   // ----------------------------------------
   initial
   begin
      o_sclk = 1'h0;
      o_cs_n = 1'h1;
      o_rd_n = 1'h1;
      o_chain = 1'h0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // Select and read enable move together, then settle through the pin lag
   task automatic select(input logic on);
      o_cs_n <= !on;
      o_rd_n <= !on;
      wait_clk(8);
   endtask

   // Fixed chain level, also the read timing choice
   task automatic set_chain(input logic lvl);
      o_chain <= lvl;
      wait_clk(8);
   endtask

   // Gapped clock idling low, slow enough for the pin lag
   // Each bit is taken before the rising edge; chain bits ride the first four edges
   task automatic read_bits(input int n, input logic [3:0] chain, output logic [31:0] val);
      val = '0;
      for (int i = 0; i < n; i++)
      begin
         if (i < 4)
            o_chain <= chain[3 - i];
         wait_clk(6);
         val = {val[30:0], i_sdo};
         o_sclk <= 1'h1;
         wait_clk(6);
         o_sclk <= 1'h0;
      end
      wait_clk(6);
   endtask
endmodule // arp_host_model
`default_nettype wire

/* File: bench/arp_readout_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module arp_readout_tb_top;
   import arp_pkg::*;
   logic clk;
   logic arst_n;
   logic [1:0] mode;
   logic [1:0] ws;
   logic css;
   logic [1:0] div;
   logic sclk_inv;
   logic sync_inv;
   logic conv_start;
   logic conv_done;
   logic sar_strobe;
   logic [RES_W-1:0] result;
   logic [RES_W-1:0] data;
   logic cs_n, rd_n, hsclk, chain;
   logic data_oe, sdo, sdo_oe, msclk, msclk_oe, sync, busy, ovr;
   // Released serial line shows the inverse of the last bit
   wire bus_sdo = sdo_oe ? sdo : !sdo;
   int err_total = 0;
   int comparisons = 0;
   logic [31:0] v;
   int n, rises, gap;
   logic ball;

   always #5 clk = ~clk;

   arp_readout DUT (.i_clk(clk), .i_arst_n(arst_n), .i_mode(mode),
      .i_word_select_address(ws), .i_cs_n(cs_n), .i_rd_n(rd_n),
      .i_clock_source_select(css), .i_read_during_convert_chain_in(chain),
      .i_serial_clock_divider(div), .i_sclk(hsclk), .i_sclk_invert(sclk_inv),
      .i_sync_invert(sync_inv), .i_conv_start(conv_start), .i_conv_done(conv_done),
      .i_result(result), .i_sar_bit_strobe(sar_strobe), .o_data(data),
      .o_data_oe(data_oe), .o_serial_data_out(sdo), .o_serial_data_out_oe(sdo_oe),
      .o_sclk(msclk), .o_sclk_oe(msclk_oe), .o_sync(sync), .o_busy(busy),
      .o_read_overrun_flag(ovr));

   arp_host_model HOST (.i_clk(clk), .i_sdo(bus_sdo), .o_sclk(hsclk), .o_cs_n(cs_n),
      .o_rd_n(rd_n), .o_chain(chain));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask

   task automatic done_pulse(input logic [17:0] r, output int np);
      result <= r;
      conv_done <= 1'h1;
      np = 0;
      tick(1);
      conv_done <= 1'h0;
      repeat (4)
      begin
         tick(1);
         np += int'(ovr === 1'h1);
      end
   endtask

   function automatic logic [17:0] exp_par(input logic [1:0] m, input logic [1:0] w,
      input logic [17:0] r);
      if (m == MODE_FULL)
         return r;
      if (m == MODE_WORD16)
         return (w == WS_FIRST) ? {2'h0, r[17:2]} : {2'h0, r[1:0], 14'h0};
      if (w == WS_FIRST)
         return {10'h0, r[17:10]};
      return (w == WS_SECOND) ? {10'h0, r[9:2]} : {10'h0, r[1:0], 6'h0};
   endfunction

   // Starts a master frame and captures bits at each rising clock inside it
   task automatic master_frame(input logic dc, input logic [17:0] r);
      logic act, sc, prev, seen;
      int t1;
      v = '0;
      rises = 0;
      gap = 0;
      ball = 1'h1;
      prev = 1'h0;
      seen = 1'h0;
      t1 = 0;
      result <= r;
      conv_done <= !dc;
      conv_start <= dc;
      for (int k = 0; k < 3000; k++)
      begin
         tick(1);
         conv_done <= 1'h0;
         conv_start <= 1'h0;
         sar_strobe <= dc && (k % (2 + k / 40)) == 0;
         act = sync ^ sync_inv;
         sc = msclk ^ sclk_inv;
         if (act)
         begin
            seen = 1'h1;
            ball &= busy;
            if (sc && !prev)
            begin
               v = {v[30:0], sdo};
               rises++;
               if (rises == 1)
                  t1 = k;
               if (rises == 2)
                  gap = k - t1;
            end
         end
         else if (seen)
            return;
         prev = sc;
      end
      err_total++;
      test_done();
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      clk = 1'h0;
      arst_n = 1'h0;
      mode = MODE_FULL;
      ws = WS_FIRST;
      css = 1'h1;
      div = 2'h0;
      sclk_inv = 1'h0;
      sync_inv = 1'h0;
      conv_start = 1'h0;
      conv_done = 1'h0;
      sar_strobe = 1'h0;
      result = 18'h0;
      tick(10);
      arst_n <= 1'h1;
      tick(5);
      HOST.select(1'h1);
      done_pulse(18'h2D5A3, n);
      for (int c = 0; c < 2; c++)
         for (int m = 0; m < 3; m++)
            for (int w = 0; w < 3; w++)
            begin
               css <= c[0];
               mode <= m[1:0];
               ws <= w[1:0];
               tick(3);
               check("data", 32'(data), 32'(exp_par(m[1:0], w[1:0], 18'h2D5A3)));
               check("data_oe", 32'(data_oe), 32'h1);
            end
      mode <= MODE_SERIAL;
      tick(3);
      check("data_oe_serial", 32'(data_oe), 32'h0);
      HOST.select(1'h0);
      mode <= MODE_WORD16;
      tick(3);
      check("data_oe_off", 32'(data_oe), 32'h0);
      $display("parallel test done");

      mode <= MODE_SERIAL;
      css <= 1'h0;
      HOST.select(1'h1);
      for (int d = 0; d < 4; d++)
      begin
         div <= d[1:0];
         sclk_inv <= (d == 1);
         sync_inv <= (d == 1);
         tick(3);
         check("sync_idle", 32'(sync), 32'(d == 1));
         check("sclk_idle", 32'(msclk), 32'(d == 1));
         check("sclk_oe", 32'(msclk_oe), 32'h1);
         master_frame(1'h0, 18'h3A5C1 ^ 18'(d));
         check("m_word", v, 32'(18'h3A5C1 ^ 18'(d)));
         check("m_rises", 32'(rises), 32'h12);
         check("m_gap", 32'(gap), 32'(2 << d));
         check("m_busy", 32'(ball), 32'h1);
         tick(3);
         check("busy_end", 32'(busy), 32'h0);
      end
      HOST.set_chain(1'h1);
      done_pulse(18'h1E0F7, n);
      master_frame(1'h1, 18'h0);
      tick(1);
      sar_strobe <= 1'h0;
      check("m_dc_word", v, 32'h1E0F7);
      check("m_dc_rises", 32'(rises), 32'h12);
      done_pulse(18'h0, n);
      $display("master test done");

      css <= 1'h1;
      HOST.set_chain(1'h0);
      HOST.select(1'h0);
      done_pulse(18'h2B3C4, n);
      HOST.read_bits(3, 4'h0, v);
      check("sdo_oe_off", 32'(sdo_oe), 32'h0);
      HOST.select(1'h1);
      check("sdo_oe", 32'(sdo_oe), 32'h1);
      check("sclk_oe_slave", 32'(msclk_oe), 32'h0);
      HOST.read_bits(22, 4'hB, v);
      check("s_word", 32'(v[21:4]), 32'h2B3C4);
      check("s_chain", 32'(v[3:0]), 32'hB);
      HOST.set_chain(1'h0);
      done_pulse(18'h2468A, n);
      HOST.read_bits(10, 4'h0, v);
      check("s_resume_hi", v, 32'(18'h2468A >> 8));
      conv_start <= 1'h1;
      tick(1);
      conv_start <= 1'h0;
      HOST.read_bits(8, 4'h0, v);
      check("s_resume_lo", v, 32'(18'h2468A & 18'h000FF));
      check("s_busy", 32'(busy), 32'h1);
      HOST.set_chain(1'h1);
      done_pulse(18'h15A5A, n);
      HOST.read_bits(18, 4'hF, v);
      check("s_dc_word", v, 32'h15A5A);
      done_pulse(18'h0C3F0, n);
      check("ovr_none", 32'(n), 32'h0);
      HOST.read_bits(10, 4'hF, v);
      check("s_part", v, 32'(18'h0C3F0 >> 8));
      done_pulse(18'h0, n);
      check("ovr_pulse", 32'(n), 32'h1);
      $display("slave test done");
      test_done();
   end
endmodule // arp_readout_tb_top
`default_nettype wire

/* File: hdl/arp_readout.sv */
// Function
// - Interface select 1 gives 16-bit word layout, 2 gives 8-bit byte layout.
// - Word select address picks two words or three bytes of one result.
// - Narrow layouts work in master and slave parallel read.
// - Interface select 3 shifts the 18-bit result out MSB first serially.
// - Exactly 18 clock pulses, each bit held across the rising edge and shifted on the falling edge.
// - Clock source select low makes the block master, generating the clock.
// - Master drives a frame strobe; strobe and clock polarity invertible.
// - Master read-during-convert input picks after-convert or during-next-convert.
// - Master during-convert clock follows SAR bit cycle, period varies.
// - Master after-convert keeps busy high until all 18 bits sent.
// - Master after-convert clock slowed by two-bit divider input.
// - Clock source select high makes the block slave on host clock.
// - Slave clock gated by chip select; data only with select and read low.
// - Slave takes continuous or gapped clock idling high or low.
// - Slave after-convert read happens after busy falls, up to 80 MHz.
// - Daisy chain only in slave after-convert, through the chain input.
// - Chain input sampled on edge opposite shifting, upstream MSB follows LSB.
// - Slave during-convert read incomplete at conversion end pulses overrun flag.
// - Select or read high puts data outputs in high impedance.
`timescale 1ns/1ns
`default_nettype none
module arp_readout
#(
   parameter int RES_WIDTH = 18
)
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [1:0] i_mode,
   input wire logic [1:0] i_word_select_address,
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   input wire logic i_clock_source_select,
   input wire logic i_read_during_convert_chain_in,
   input wire logic [1:0] i_serial_clock_divider,
   input wire logic i_sclk,
   input wire logic i_sclk_invert,
   input wire logic i_sync_invert,
   input wire logic i_conv_start,
   input wire logic i_conv_done,
   input wire logic [arp_pkg::RES_W-1:0] i_result,
   input wire logic i_sar_bit_strobe,
   output logic [arp_pkg::RES_W-1:0] o_data,
   output logic o_data_oe,
   output logic o_serial_data_out,
   output logic o_serial_data_out_oe,
   output logic o_sclk,
   output logic o_sclk_oe,
   output logic o_sync,
   output logic o_busy,
   output logic o_read_overrun_flag
);
   import arp_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [SYNC_LANES-1:0] sync_s1;
   logic [SYNC_LANES-1:0] sync_s2;
   logic [SYNC_LANES-1:0] sync_s3;
   logic [SYNC_LANES-1:0] lvl;
   wire [SYNC_LANES-1:0] pins = {i_read_during_convert_chain_in, i_rd_n, i_cs_n, i_sclk};

   genvar g;
   generate
      for (g = 0; g < SYNC_LANES; g++)
      begin : g_sync
         always_ff @(posedge i_clk or negedge i_arst_n)
         begin
            if (!i_arst_n)
            begin
               sync_s1[g] <= SYNC_RST[g];
               sync_s2[g] <= SYNC_RST[g];
               sync_s3[g] <= SYNC_RST[g];
               lvl[g] <= SYNC_RST[g];
            end
            else
            begin
               sync_s1[g] <= pins[g];
               sync_s2[g] <= sync_s1[g];
               sync_s3[g] <= sync_s2[g];
               if (sync_s2[g] == sync_s3[g])
                  lvl[g] <= sync_s3[g];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   wire serial_mode = (i_mode == MODE_SERIAL);
   wire master = serial_mode && !i_clock_source_select;
   wire slave = serial_mode && i_clock_source_select;
   wire rdc = lvl[LANE_CHAIN];
   wire m_rac = master && !rdc;
   wire m_rdc = master && rdc;
   wire s_rdc = slave && rdc;
   wire selected = !lvl[LANE_CS] && !lvl[LANE_RD];

   // ----------------------------------------
   // Result store
   // ----------------------------------------
   logic [RES_W-1:0] stored;

   arp_result_store #(.WIDTH(RES_W), .DEPTH(2)) u_store
   (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_wr(i_conv_done),
      .i_wdata(i_result),
      .o_rdata(stored)
   );

   // ----------------------------------------
   // Parallel word selection
   // ----------------------------------------
   wire [15:0] w16_hi = stored[W16_HI_LSB +: 16];
   wire [15:0] w16_lo = {stored[W16_HI_LSB-1:0], 14'h0000};
   wire [7:0] b8_hi = stored[B8_HI_LSB +: 8];
   wire [7:0] b8_mid = stored[B8_MID_LSB +: 8];
   wire [7:0] b8_lo = {stored[B8_MID_LSB-1:0], 6'h00};
   wire [15:0] w16_sel = (i_word_select_address == WS_FIRST) ? w16_hi : w16_lo;
   wire [7:0] b8_sel = (i_word_select_address == WS_FIRST) ? b8_hi :
                       (i_word_select_address == WS_SECOND) ? b8_mid : b8_lo;
   wire [RES_W-1:0] next_data = (i_mode == MODE_WORD16) ? {2'h0, w16_sel} :
                                (i_mode == MODE_BYTE8) ? {10'h000, b8_sel} :
                                (i_mode == MODE_FULL) ? stored : '0;

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_data <= '0;
      else
         o_data <= next_data;
   end

   assign o_data_oe = !serial_mode && selected;

   // ----------------------------------------
   // Slave clock edges
   // ----------------------------------------
   logic sclk_prev;
   logic chain_bit;
   wire s_gate = slave && selected && !lvl[LANE_CS];
   wire s_rise = s_gate && lvl[LANE_SCLK] && !sclk_prev;
   wire s_fall = s_gate && !lvl[LANE_SCLK] && sclk_prev;

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         sclk_prev <= 1'b0;
         chain_bit <= 1'b0;
      end
      else
      begin
         sclk_prev <= lvl[LANE_SCLK];
         if (s_rise)
            chain_bit <= lvl[LANE_CHAIN];
      end
   end

   // ----------------------------------------
   // Master clock generation
   // ----------------------------------------
   arp_mst_t mst;
   logic sclk_int;
   logic [7:0] div_cnt;
   logic [4:0] m_cnt;
   logic m_rac_frame;
   wire [7:0] half_cyc = 8'(MSCLK_HALF_CYC << i_serial_clock_divider);
   wire div_tick = (div_cnt == 8'h01);
   wire m_tick = (mst == ARP_M_RUN) && (m_rdc ? i_sar_bit_strobe : div_tick);
   wire m_start = (m_rac && i_conv_done) || (m_rdc && i_conv_start);
   wire m_fall = m_tick && sclk_int;
   wire m_end = m_fall && (m_cnt == RES_BITS);

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         div_cnt <= 8'h01;
      else if (m_start || div_tick)
         div_cnt <= half_cyc;
      else
         div_cnt <= div_cnt - 8'h01;
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         mst <= ARP_M_IDLE;
         sclk_int <= 1'b0;
         m_cnt <= 5'h00;
         m_rac_frame <= 1'b0;
      end
      else
      begin
         case (mst)
            ARP_M_IDLE:
            begin
               sclk_int <= 1'b0;
               m_cnt <= 5'h00;
               if (m_start)
               begin
                  mst <= ARP_M_RUN;
                  m_rac_frame <= m_rac;
               end
            end
            ARP_M_RUN:
            begin
               if (!master)
               begin
                  mst <= ARP_M_IDLE;
                  m_rac_frame <= 1'b0;
               end
               else if (m_end)
               begin
                  mst <= ARP_M_IDLE;
                  sclk_int <= 1'b0;
                  m_rac_frame <= 1'b0;
               end
               else if (m_tick)
               begin
                  sclk_int <= !sclk_int;
                  if (!sclk_int)
                     m_cnt <= m_cnt + 5'h01;
               end
            end
            default:
               mst <= ARP_M_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Shared shift register
   // ----------------------------------------
   logic [RES_W-1:0] shift;
   logic [4:0] s_cnt;
   logic s_loaded;
   wire load_m = m_start;
   wire load_s = slave && i_conv_done;
   wire [RES_W-1:0] load_val = (m_rdc || slave) ? stored : i_result;
   wire shift_m = m_fall && !m_end;
   wire in_bit = chain_bit;
   wire s_short = s_loaded && (s_cnt < RES_BITS);

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         shift <= '0;
         s_cnt <= 5'h00;
         s_loaded <= 1'b0;
      end
      else if (load_m)
      begin
         shift <= load_val;
      end
      else if (load_s)
      begin
         shift <= i_result;
         s_cnt <= 5'h00;
         s_loaded <= 1'b1;
      end
      else if (shift_m)
      begin
         shift <= {shift[RES_W-2:0], 1'b0};
      end
      else if (s_fall)
      begin
         shift <= {shift[RES_W-2:0], in_bit};
         if (s_cnt != RES_BITS)
            s_cnt <= s_cnt + 5'h01;
      end
   end

   // ----------------------------------------
   // Overrun pulse and busy
   // ----------------------------------------
   logic converting;

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_read_overrun_flag <= 1'b0;
         converting <= 1'b0;
      end
      else
      begin
         o_read_overrun_flag <= s_rdc && i_conv_done && s_short;
         if (i_conv_start)
            converting <= 1'b1;
         else if (i_conv_done)
            converting <= 1'b0;
      end
   end

   assign o_busy = converting || m_rac_frame;

   // ----------------------------------------
   // Serial outputs
   // ----------------------------------------
   assign o_serial_data_out = shift[RES_W-1];
   assign o_serial_data_out_oe = serial_mode && selected;
   assign o_sclk = sclk_int ^ i_sclk_invert;
   assign o_sclk_oe = master && selected;
   assign o_sync = (mst == ARP_M_RUN) ^ i_sync_invert;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_hiz;
      @(posedge i_clk) disable iff (!i_arst_n)
      (lvl[LANE_CS] || lvl[LANE_RD]) |-> !o_data_oe && !o_serial_data_out_oe;
   endproperty
   a_hiz: assert property (p_hiz) else $error("outputs driven while deselected");

   property p_busy_frame;
      @(posedge i_clk) disable iff (!i_arst_n)
      (m_rac && i_conv_done && mst == ARP_M_IDLE) |=> o_busy [*2];
   endproperty
   a_busy_frame: assert property (p_busy_frame) else $error("busy fell early");

   property p_overrun;
      @(posedge i_clk) disable iff (!i_arst_n)
      (s_rdc && i_conv_done && s_loaded && s_cnt < RES_BITS) |=> o_read_overrun_flag;
   endproperty
   a_overrun: assert property (p_overrun) else $error("missed overrun pulse");

   property p_overrun_pulse;
      @(posedge i_clk) disable iff (!i_arst_n)
      o_read_overrun_flag |-> $past(i_conv_done) && $past(s_cnt) != RES_BITS;
   endproperty
   a_overrun_pulse: assert property (p_overrun_pulse) else $error("spurious overrun");

   property p_pulse_cnt;
      @(posedge i_clk) disable iff (!i_arst_n)
      m_end |-> m_cnt == 5'h12;
   endproperty
   a_pulse_cnt: assert property (p_pulse_cnt) else $error("frame not 18 pulses");

   property p_slave_no_clk;
      @(posedge i_clk) disable iff (!i_arst_n)
      i_clock_source_select |-> !o_sclk_oe;
   endproperty
   a_slave_no_clk: assert property (p_slave_no_clk) else $error("slave drives clock");

   property p_rdc_start;
      @(posedge i_clk) disable iff (!i_arst_n)
      (m_rdc && i_conv_start && mst == ARP_M_IDLE) |=> mst == ARP_M_RUN && shift == $past(stored);
   endproperty
   a_rdc_start: assert property (p_rdc_start) else $error("during-convert frame not started");

   property p_div_hold;
      @(posedge i_clk) disable iff (!i_arst_n)
      (mst == ARP_M_RUN && master && !m_tick) |=> $stable(sclk_int);
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("clock moved without tick");

   property p_gate;
      @(posedge i_clk) disable iff (!i_arst_n)
      (slave && !selected && !i_conv_done) |=> $stable(s_cnt);
   endproperty
   a_gate: assert property (p_gate) else $error("shift while deselected");

   property p_word16;
      @(posedge i_clk) disable iff (!i_arst_n)
      (i_mode == MODE_WORD16 && i_word_select_address == WS_FIRST)
         |=> o_data[15:0] == $past(stored[17:2]);
   endproperty
   a_word16: assert property (p_word16) else $error("wrong 16-bit word");

   c_master_frame: cover property (@(posedge i_clk) disable iff (!i_arst_n) m_end);
   c_overrun: cover property (@(posedge i_clk) disable iff (!i_arst_n) o_read_overrun_flag);
   c_slave_done: cover property (@(posedge i_clk) disable iff (!i_arst_n)
      s_fall && s_cnt == 5'h11);
endmodule // arp_readout
`default_nettype wire

/* File: hdl/arp_result_store.sv */
`timescale 1ns/1ns
`default_nettype none
module arp_result_store
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = 2
)
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_wr,
   input wire logic [WIDTH-1:0] i_wdata,
   output logic [WIDTH-1:0] o_rdata
);
   // ----------------------------------------
   // Result history, newest at entry 0
   // ----------------------------------------
   logic [WIDTH-1:0] mem [DEPTH];

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : g_ent
         always_ff @(posedge i_clk or negedge i_arst_n)
         begin
            if (!i_arst_n)
               mem[g] <= '0;
            else if (i_wr)
               mem[g] <= (g == 0) ? i_wdata : mem[(g == 0) ? 0 : g-1];
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_rdata <= '0;
      else
         o_rdata <= mem[0];
   end
endmodule // arp_result_store
`default_nettype wire

/* File: shared/arp_pkg.sv */
`default_nettype none
package arp_pkg;
   // ----------------------------------------
   // Interface select codes
   // ----------------------------------------
   localparam logic [1:0] MODE_FULL = 2'h0;
   localparam logic [1:0] MODE_WORD16 = 2'h1;
   localparam logic [1:0] MODE_BYTE8 = 2'h2;
   localparam logic [1:0] MODE_SERIAL = 2'h3;
   // ----------------------------------------
   // Result and field layout
   // ----------------------------------------
   localparam int RES_W = 18;
   localparam logic [4:0] RES_BITS = 5'h12;
   localparam int W16_HI_LSB = 2;
   localparam int B8_HI_LSB = 10;
   localparam int B8_MID_LSB = 2;
   localparam logic [1:0] WS_FIRST = 2'h0;
   localparam logic [1:0] WS_SECOND = 2'h1;
   localparam logic [1:0] WS_THIRD = 2'h2;
   // ----------------------------------------
   // Pin synchroniser lanes
   // ----------------------------------------
   localparam int SYNC_LANES = 4;
   localparam int LANE_SCLK = 0;
   localparam int LANE_CS = 1;
   localparam int LANE_RD = 2;
   localparam int LANE_CHAIN = 3;
   localparam logic [SYNC_LANES-1:0] SYNC_RST = 4'h6;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int MSCLK_HALF_NS = 10;
   localparam logic [7:0] MSCLK_HALF_CYC =
      8'((MSCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // ----------------------------------------
   // Master serial states
   // ----------------------------------------
   typedef enum logic [0:0] {ARP_M_IDLE, ARP_M_RUN} arp_mst_t;
endpackage
`default_nettype wire
